// file: rtl/dtc_cfg.svh
// dtc_cfg.svh: register offsets, field positions and reset values
// assumes: included by the timer package users, one Wishbone word per reg
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH

// byte addresses of the register words
`define DTC_ADDR_MODE 8'h00
`define DTC_ADDR_CTRL 8'h04
`define DTC_ADDR_FREQ 8'h08
`define DTC_ADDR_IEN 8'h0c
`define DTC_ADDR_T0L 8'h10
`define DTC_ADDR_T0H 8'h14
`define DTC_ADDR_T1L 8'h18
`define DTC_ADDR_T1H 8'h1c

// mode register fields
`define DTC_MODE_T0_LSB 0
`define DTC_MODE_T0_CT 2
`define DTC_MODE_T1_LSB 4
`define DTC_MODE_T1_CT 6
// control register fields
`define DTC_CTRL_T0_RUN 4
`define DTC_CTRL_T0_OVF 5
`define DTC_CTRL_T1_RUN 6
`define DTC_CTRL_T1_OVF 7
// frequency control fields
`define DTC_FREQ_T0_FD 0
`define DTC_FREQ_T1_FD 1
// interrupt enable fields
`define DTC_IEN_T0 0
`define DTC_IEN_T1 1

`define DTC_RST_BYTE 8'h00
`define DTC_PRESCALE_DIV 4'd12
`define DTC_UNMAPPED_DATA 32'h0000_0000

`endif

// file: rtl/dtc_pkg.sv
// dtc_pkg.sv: types shared by the dual timer/counter
// assumes: constants come from dtc_cfg.svh
package dtc_pkg;

    typedef enum logic [1:0] {
        DTC_MODE_13BIT,
        DTC_MODE_16BIT,
        DTC_MODE_RELOAD,
        DTC_MODE_SPLIT
    } dtc_mode_t;

    typedef enum logic {
        DTC_BUS_IDLE,
        DTC_BUS_ACK
    } dtc_bus_state_t;

endpackage

// file: rtl/dtc_timer.sv
// dtc_timer.sv: two 8051-style timer/counters behind a Wishbone slave
// assumes: one 200 MHz clock, count pins synchronous to it,
// classic Wishbone master holding each request until ack
//
// How it works
// - timer0 has four modes from mode field
// - 00 13-bit, 01 16-bit, 10 reload, 11 split/stop
// - mode 0: high byte plus low five bits
// - timer0 overflow sets flag, interrupt if enabled
// - counter select: count pin falls, else prescaled
// - run bit resumes counting from held value
// - timer0 prescale select picks division ratio
// - prescale 0 gives clock/12, 1 undivided
// - mode 1: full sixteen bits counted
// - mode 2: low byte reloads from high byte
// - split: low byte uses timer0 controls
// - split: high byte uses timer1 run, flag
// - split: timer1 own counter stops
// - timer1 has three counting modes
// - timer1 mode 11 stops counting
// - timer1 mode 0: thirteen bits, flag, interrupt
// - timer1 counter select: pin falls or prescaled
// - timer1 run bit resumes from held value
// - timer1 mode 1: full sixteen bits
// - timer1 mode 2: reload from high byte
// - timer1 prescale select picks division ratio
`timescale 1ns/100ps
`include "dtc_cfg.svh"

module dtc_timer
    import dtc_pkg::*;
(
    // clock and reset
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    // wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // count pins
    input wire logic timer0_count_pin_i,
    input wire logic timer1_count_pin_i,
    // interrupt requests to the core
    output logic timer0_irq_o,
    output logic timer1_irq_o
);

    ////////////////////////////////////////////////////////////////////
    // register state
    logic [7:0] timer_mode_register_q;
    logic timer0_run_bit_q;
    logic timer1_run_bit_q;
    logic timer0_overflow_flag_q;
    logic timer1_overflow_flag_q;
    logic timer0_prescale_select_q;
    logic timer1_prescale_select_q;
    logic [1:0] irq_enable_q;
    logic [7:0] timer0_low_byte_q;
    logic [7:0] timer0_high_byte_q;
    logic [7:0] timer1_low_byte_q;
    logic [7:0] timer1_high_byte_q;
    dtc_bus_state_t bus_state_q;

    dtc_mode_t t0_mode;
    dtc_mode_t t1_mode;
    logic timer0_counter_select;
    logic timer1_counter_select;

    // mode fields decoded from the mode register
    assign t0_mode = dtc_mode_t'(timer_mode_register_q[`DTC_MODE_T0_LSB +: 2]);
    assign t1_mode = dtc_mode_t'(timer_mode_register_q[`DTC_MODE_T1_LSB +: 2]);
    assign timer0_counter_select = timer_mode_register_q[`DTC_MODE_T0_CT];
    assign timer1_counter_select = timer_mode_register_q[`DTC_MODE_T1_CT];

    function automatic logic addr_hit(input logic [7:0] adr,
                                      input logic [7:0] reg_adr);
        addr_hit = (adr == reg_adr);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // wishbone handshake: one wait state, ack drops after one cycle
    logic bus_req;
    logic wr_en;
    assign bus_req = wb_cyc_i && wb_stb_i && (bus_state_q == DTC_BUS_IDLE);
    assign wr_en = bus_req && wb_we_i && wb_sel_i[0];

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            bus_state_q <= DTC_BUS_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            case (bus_state_q)
                DTC_BUS_IDLE: begin
                    wb_ack_o <= bus_req;
                    if (bus_req) begin
                        bus_state_q <= DTC_BUS_ACK;
                    end
                end
                DTC_BUS_ACK: begin
                    wb_ack_o <= 1'b0;
                    bus_state_q <= DTC_BUS_IDLE;
                end
                default: begin
                    wb_ack_o <= 1'b0;
                    bus_state_q <= DTC_BUS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // prescaler: one enable in twelve, or every cycle
    logic [3:0] pre_cnt_q;
    logic tick_div12;
    assign tick_div12 = (pre_cnt_q == `DTC_PRESCALE_DIV - 4'd1);

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            pre_cnt_q <= 4'h0;
        end else if (tick_div12) begin
            pre_cnt_q <= 4'h0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 4'd1;
        end
    end

    logic t0_tick_timer;
    logic t1_tick_timer;
    // ratio choice per timer
    assign t0_tick_timer = timer0_prescale_select_q ? 1'b1 : tick_div12;
    assign t1_tick_timer = timer1_prescale_select_q ? 1'b1 : tick_div12;

    ////////////////////////////////////////////////////////////////////
    // count pin falling edge detect
    logic [1:0] pin_prev_q;
    logic [1:0] pin_fall;
    logic [1:0] pins;
    assign pins = {timer1_count_pin_i, timer0_count_pin_i};

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_pin
            // pins are synchronous, so one stage is enough
            always_ff @(posedge mclk_i) begin
                if (sys_rst_i) begin
                    pin_prev_q[gi] <= 1'b1;
                end else begin
                    pin_prev_q[gi] <= pins[gi];
                end
            end
            assign pin_fall[gi] = pin_prev_q[gi] && !pins[gi];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // count enables
    logic t0_inc;
    logic t1_inc;
    logic t0h_inc;
    // low part of timer0
    assign t0_inc = timer0_run_bit_q &&
                    (timer0_counter_select ? pin_fall[0] : t0_tick_timer);
    // split high byte: prescaled only, timer1 run bit
    assign t0h_inc = (t0_mode == DTC_MODE_SPLIT) && timer1_run_bit_q &&
                     t0_tick_timer;
    // timer1 stalls in split or in mode 11
    assign t1_inc = timer1_run_bit_q && (t0_mode != DTC_MODE_SPLIT) &&
                    (t1_mode != DTC_MODE_SPLIT) &&
                    (timer1_counter_select ? pin_fall[1] : t1_tick_timer);

    // shared step: returns {overflow, high, low}
    function automatic logic [16:0] step(input dtc_mode_t mode,
                                         input logic [7:0] hi,
                                         input logic [7:0] lo);
        logic [5:0] lo5;
        logic [8:0] hi9;
        logic [8:0] lo9;
        lo5 = 6'h00;
        hi9 = 9'h000;
        lo9 = 9'h000;
        step = {1'b0, hi, lo};
        case (mode)
            DTC_MODE_13BIT: begin
                lo5 = {1'b0, lo[4:0]} + 6'd1;
                hi9 = {1'b0, hi} + {8'h00, lo5[5]};
                step = {hi9[8], hi9[7:0], lo[7:5], lo5[4:0]};
            end
            DTC_MODE_16BIT: begin
                lo9 = {1'b0, lo} + 9'd1;
                hi9 = {1'b0, hi} + {8'h00, lo9[8]};
                step = {hi9[8], hi9[7:0], lo9[7:0]};
            end
            DTC_MODE_RELOAD: begin
                lo9 = {1'b0, lo} + 9'd1;
                step = lo9[8] ? {1'b1, hi, hi} : {1'b0, hi, lo9[7:0]};
            end
            DTC_MODE_SPLIT: begin
                lo9 = {1'b0, lo} + 9'd1;
                step = {lo9[8], hi, lo9[7:0]};
            end
            default: begin
                step = {1'b0, hi, lo};
            end
        endcase
    endfunction

    logic [16:0] t0_next;
    logic [16:0] t1_next;
    logic [8:0] t0h_split;
    assign t0_next = step(t0_mode, timer0_high_byte_q, timer0_low_byte_q);
    assign t1_next = step(t1_mode, timer1_high_byte_q, timer1_low_byte_q);
    assign t0h_split = {1'b0, timer0_high_byte_q} + 9'd1;

    logic t0_ovf;
    logic t1_ovf;
    logic t0h_ovf;
    assign t0_ovf = t0_inc && t0_next[16];
    assign t1_ovf = t1_inc && t1_next[16];
    assign t0h_ovf = t0h_inc && t0h_split[8];

    logic wr_t0l;
    logic wr_t0h;
    logic wr_t1l;
    logic wr_t1h;
    logic wr_ctrl;
    assign wr_t0l = wr_en && addr_hit(wb_adr_i, `DTC_ADDR_T0L);
    assign wr_t0h = wr_en && addr_hit(wb_adr_i, `DTC_ADDR_T0H);
    assign wr_t1l = wr_en && addr_hit(wb_adr_i, `DTC_ADDR_T1L);
    assign wr_t1h = wr_en && addr_hit(wb_adr_i, `DTC_ADDR_T1H);
    assign wr_ctrl = wr_en && addr_hit(wb_adr_i, `DTC_ADDR_CTRL);

    ////////////////////////////////////////////////////////////////////
    // timer0 count bytes; software write wins over counting
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timer0_low_byte_q <= `DTC_RST_BYTE;
            timer0_high_byte_q <= `DTC_RST_BYTE;
        end else begin
            if (wr_t0l) begin
                timer0_low_byte_q <= wb_dat_i[7:0];
            end else if (t0_inc) begin
                timer0_low_byte_q <= t0_next[7:0];
            end
            if (wr_t0h) begin
                timer0_high_byte_q <= wb_dat_i[7:0];
            end else if (t0h_inc) begin
                timer0_high_byte_q <= t0h_split[7:0];
            end else if (t0_inc && t0_mode != DTC_MODE_SPLIT) begin
                timer0_high_byte_q <= t0_next[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // timer1 count bytes
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timer1_low_byte_q <= `DTC_RST_BYTE;
            timer1_high_byte_q <= `DTC_RST_BYTE;
        end else begin
            if (wr_t1l) begin
                timer1_low_byte_q <= wb_dat_i[7:0];
            end else if (t1_inc) begin
                timer1_low_byte_q <= t1_next[7:0];
            end
            if (wr_t1h) begin
                timer1_high_byte_q <= wb_dat_i[7:0];
            end else if (t1_inc) begin
                timer1_high_byte_q <= t1_next[15:8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // control, flags: hardware set wins over software clear
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timer0_run_bit_q <= 1'b0;
            timer1_run_bit_q <= 1'b0;
            timer0_overflow_flag_q <= 1'b0;
            timer1_overflow_flag_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                timer0_run_bit_q <= wb_dat_i[`DTC_CTRL_T0_RUN];
                timer1_run_bit_q <= wb_dat_i[`DTC_CTRL_T1_RUN];
            end
            if (t0_ovf) begin
                timer0_overflow_flag_q <= 1'b1;
            end else if (wr_ctrl) begin
                timer0_overflow_flag_q <= wb_dat_i[`DTC_CTRL_T0_OVF];
            end
            if (t1_ovf || t0h_ovf) begin
                timer1_overflow_flag_q <= 1'b1;
            end else if (wr_ctrl) begin
                timer1_overflow_flag_q <= wb_dat_i[`DTC_CTRL_T1_OVF];
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timer_mode_register_q <= `DTC_RST_BYTE;
            timer0_prescale_select_q <= 1'b0;
            timer1_prescale_select_q <= 1'b0;
            irq_enable_q <= 2'b00;
        end else begin
            if (wr_en && addr_hit(wb_adr_i, `DTC_ADDR_MODE)) begin
                timer_mode_register_q <= wb_dat_i[7:0] & 8'h77;
            end
            if (wr_en && addr_hit(wb_adr_i, `DTC_ADDR_FREQ)) begin
                timer0_prescale_select_q <= wb_dat_i[`DTC_FREQ_T0_FD];
                timer1_prescale_select_q <= wb_dat_i[`DTC_FREQ_T1_FD];
            end
            if (wr_en && addr_hit(wb_adr_i, `DTC_ADDR_IEN)) begin
                irq_enable_q <= wb_dat_i[1:0];
            end
        end
    end

    // interrupt lines follow flag and enable, one cycle late
    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            timer0_irq_o <= 1'b0;
            timer1_irq_o <= 1'b0;
        end else begin
            timer0_irq_o <= timer0_overflow_flag_q &&
                            irq_enable_q[`DTC_IEN_T0];
            timer1_irq_o <= timer1_overflow_flag_q &&
                            irq_enable_q[`DTC_IEN_T1];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data, registered with the ack
    logic [31:0] rd_data;
    always_comb begin
        rd_data = `DTC_UNMAPPED_DATA;
        case (wb_adr_i)
            `DTC_ADDR_MODE: rd_data[7:0] = timer_mode_register_q;
            `DTC_ADDR_CTRL: begin
                rd_data[`DTC_CTRL_T0_RUN] = timer0_run_bit_q;
                rd_data[`DTC_CTRL_T0_OVF] = timer0_overflow_flag_q;
                rd_data[`DTC_CTRL_T1_RUN] = timer1_run_bit_q;
                rd_data[`DTC_CTRL_T1_OVF] = timer1_overflow_flag_q;
            end
            `DTC_ADDR_FREQ: begin
                rd_data[`DTC_FREQ_T0_FD] = timer0_prescale_select_q;
                rd_data[`DTC_FREQ_T1_FD] = timer1_prescale_select_q;
            end
            `DTC_ADDR_IEN: rd_data[1:0] = irq_enable_q;
            // top three low bits in mode 0 are don't-care for software
            `DTC_ADDR_T0L: rd_data[7:0] = timer0_low_byte_q;
            `DTC_ADDR_T0H: rd_data[7:0] = timer0_high_byte_q;
            `DTC_ADDR_T1L: rd_data[7:0] = timer1_low_byte_q;
            `DTC_ADDR_T1H: rd_data[7:0] = timer1_high_byte_q;
            default: rd_data = `DTC_UNMAPPED_DATA;
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (sys_rst_i) begin
            wb_dat_o <= `DTC_UNMAPPED_DATA;
        end else if (bus_req && !wb_we_i) begin
            wb_dat_o <= rd_data;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // checks
    sequence s_wrap_low;
        t0_inc && t0_mode == DTC_MODE_RELOAD && timer0_low_byte_q == 8'hff
            && !wr_t0l && !wr_t0h;
    endsequence

    a_t0_reload_val: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        s_wrap_low |=> timer0_low_byte_q == $past(timer0_high_byte_q)
            && timer0_overflow_flag_q)
        else $error("timer0 reload wrong");

    a_t1_reload_val: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        t1_inc && t1_mode == DTC_MODE_RELOAD && timer1_low_byte_q == 8'hff
            && !wr_t1l && !wr_t1h
        |=> timer1_low_byte_q == $past(timer1_high_byte_q))
        else $error("timer1 reload wrong");

    a_t1_stop_split: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        t0_mode == DTC_MODE_SPLIT && !wr_t1l && !wr_t1h
        |=> $stable(timer1_low_byte_q) && $stable(timer1_high_byte_q))
        else $error("timer1 moved in split");

    a_t1_mode3_stop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        t1_mode == DTC_MODE_SPLIT && !wr_t1l
        |=> $stable(timer1_low_byte_q))
        else $error("timer1 moved in mode 3");

    a_t0_hold_stop: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        !timer0_run_bit_q && !wr_t0l |=> $stable(timer0_low_byte_q))
        else $error("timer0 counted while stopped");

    a_flag_sticky: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        timer0_overflow_flag_q && !wr_ctrl |=> timer0_overflow_flag_q)
        else $error("timer0 flag lost");

    a_pin_one_inc: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        pin_fall[0] |=> !pin_fall[0])
        else $error("double count edge");

    a_div12_gap: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        tick_div12 |=> !tick_div12 [*8] ##1 !tick_div12 [*3]
            ##1 tick_div12)
        else $error("prescaler period wrong");

    a_irq_follow: assert property (@(posedge mclk_i) disable iff (sys_rst_i)
        t0_ovf && irq_enable_q[`DTC_IEN_T0] && !wr_ctrl
            && !(wr_en && addr_hit(wb_adr_i, `DTC_ADDR_IEN))
        |-> ##2 timer0_irq_o)
        else $error("timer0 irq missing");

endmodule

// file: tb/dtc_pin_model.sv
// dtc_pin_model.sv: drives the two external count pins
// assumes: pins idle high and change only just after a rising edge
`timescale 1ns/100ps

module dtc_pin_model (
    // clock
    input wire logic mclk_i,
    // count pins
    output logic pin0_o,
    output logic pin1_o
);

initial begin
    pin0_o = 1'b1;
    pin1_o = 1'b1;
end

// low held three cycles so a slow edge detector still sees one fall
task automatic fall(input int t, input int n);
    repeat (n) begin
        @(posedge mclk_i);
        if (t == 0) pin0_o <= 1'b0;
        else pin1_o <= 1'b0;
        repeat (3) @(posedge mclk_i);
        if (t == 0) pin0_o <= 1'b1;
        else pin1_o <= 1'b1;
        repeat (3) @(posedge mclk_i);
    end
endtask

endmodule

// file: tb/tb_dtc_timer.sv
// tb_dtc_timer.sv: self-checking bench for the dual timer/counter
// assumes: wishbone slave acks one cycle after taking a request
`timescale 1ns/100ps
`include "dtc_cfg.svh"

module tb_dtc_timer;
import dtc_pkg::*;

logic mclk_i = 1'b0;
logic sys_rst_i = 1'b1;
logic wb_cyc = 1'b0;
logic wb_stb = 1'b0;
logic wb_we = 1'b0;
logic [7:0] wb_adr = 8'h00;
logic [3:0] wb_sel = 4'h0;
logic [3:0] sel_v = 4'hf;
logic [31:0] wb_dat_w = 32'h0;
logic [31:0] wb_dat_o;
logic wb_ack_o;
logic pin0;
logic pin1;
logic timer0_irq_o;
logic timer1_irq_o;
int error_cnt = 0;
int num_checks = 0;
logic [31:0] d;
logic [7:0] a;
logic [7:0] run;
logic [7:0] flg;
logic [7:0] msk;
int c_t[8] = '{0, 0, 0, 0, 1, 1, 1, 1};
logic [1:0] c_m[8] = '{0, 1, 1, 2, 0, 1, 2, 3};
logic [7:0] c_lo[8] = '{8'h1e, 8'hfd, 8'hff, 8'hfe, 8'h1f, 8'hff, 8'hff, 8'h10};
logic [7:0] c_hi[8] = '{8'hff, 8'hff, 8'h12, 8'h80, 8'h00, 8'hff, 8'h40, 8'h20};
int c_n[8] = '{2, 3, 1, 3, 1, 1, 2, 3};
logic [7:0] e_lo[8] = '{8'h00, 8'h00, 8'h00, 8'h81, 8'h00, 8'h00, 8'h41, 8'h10};
logic [7:0] e_hi[8] = '{8'h00, 8'h00, 8'h13, 8'h80, 8'h01, 8'h00, 8'h40, 8'h20};
logic e_f[8] = '{1, 1, 0, 1, 0, 1, 1, 0};

initial begin
    forever #2.5 mclk_i = ~mclk_i;
end

dtc_timer DUT (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .wb_cyc_i(wb_cyc),
    .wb_stb_i(wb_stb),
    .wb_we_i(wb_we),
    .wb_adr_i(wb_adr),
    .wb_sel_i(wb_sel),
    .wb_dat_i(wb_dat_w),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .timer0_count_pin_i(pin0),
    .timer1_count_pin_i(pin1),
    .timer0_irq_o(timer0_irq_o),
    .timer1_irq_o(timer1_irq_o)
);

dtc_pin_model pins (
    .mclk_i(mclk_i),
    .pin0_o(pin0),
    .pin1_o(pin1)
);

////////////////////////////////////////////////////////////////////////////
task automatic finish_test();
    if (error_cnt == 0 && num_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
endtask

task automatic check(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
        error_cnt++;
        $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
endtask

// held until ack; the watchdog ends a wait that never sees it
task automatic xfer(input logic we, input logic [7:0] adr,
                    input logic [7:0] wd, output logic [31:0] rd);
    @(posedge mclk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= adr;
    wb_sel <= sel_v;
    wb_dat_w <= {24'h0, wd};
    do @(posedge mclk_i); while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
endtask

task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    logic [31:0] x;
    xfer(1'b1, adr, wd, x);
endtask

task automatic rd_chk(input logic [7:0] adr, input logic [7:0] m,
                      input logic [7:0] exp, input string name);
    logic [31:0] x;
    xfer(1'b0, adr, 8'h00, x);
    // upper bits must read zero, so they stay in the compare
    check(name, x & {24'hff_ffff, m}, {24'h0, exp});
endtask

// run a timer in timer mode for a fixed span, then stop and read it
task automatic presc(input int t, input logic fd, input int lo, input int hi);
    logic [31:0] x;
    wr(`DTC_ADDR_MODE, 8'h11);
    wr(`DTC_ADDR_FREQ, {6'h0, fd, fd});
    wr(t ? `DTC_ADDR_T1L : `DTC_ADDR_T0L, 8'h00);
    wr(t ? `DTC_ADDR_T1H : `DTC_ADDR_T0H, 8'h00);
    wr(`DTC_ADDR_CTRL, t ? 8'h40 : 8'h10);
    repeat (120) @(posedge mclk_i);
    wr(`DTC_ADDR_CTRL, 8'h00);
    xfer(1'b0, t ? `DTC_ADDR_T1L : `DTC_ADDR_T0L, 8'h00, x);
    check("prescaled count", {31'h0, x >= lo && x <= hi}, 32'h1);
endtask

initial begin
    #100us;
    error_cnt++;
    finish_test();
end

////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (10) @(posedge mclk_i);
    sys_rst_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 9; i++) rd_chk(8'(i * 4), 8'hff, 8'h00, "reset value");
    wr(8'h20, 8'h5a);
    rd_chk(8'h20, 8'hff, 8'h00, "unmapped");
    // write with the low byte lane off must be ignored
    sel_v = 4'he;
    wr(`DTC_ADDR_T0L, 8'h33);
    sel_v = 4'hf;
    rd_chk(`DTC_ADDR_T0L, 8'hff, 8'h00, "sel gate");
    wr(`DTC_ADDR_IEN, 8'h03);
    // one pass per mode of timer1 and per mode 00-10 of timer0 (mode 01 twice), counting pin falls
    for (int i = 0; i < 8; i++) begin
        a = c_t[i] ? `DTC_ADDR_T1L : `DTC_ADDR_T0L;
        run = c_t[i] ? 8'h40 : 8'h10;
        flg = c_t[i] ? 8'h80 : 8'h20;
        msk = (c_m[i] == 2'd0) ? 8'h1f : 8'hff;
        wr(`DTC_ADDR_MODE, c_t[i] ? {2'b01, c_m[i], 4'h0} : {6'h01, c_m[i]});
        wr(a, c_lo[i]);
        wr(a + 8'h04, c_hi[i]);
        wr(`DTC_ADDR_CTRL, run);
        pins.fall(c_t[i], c_n[i]);
        rd_chk(a, msk, e_lo[i], "low byte");
        rd_chk(a + 8'h04, 8'hff, e_hi[i], "high byte");
        rd_chk(`DTC_ADDR_CTRL, 8'hff, run | (e_f[i] ? flg : 8'h00), "flags");
        check("irq", c_t[i] ? timer1_irq_o : timer0_irq_o, e_f[i]);
        wr(`DTC_ADDR_CTRL, 8'h00);
        rd_chk(`DTC_ADDR_CTRL, 8'hff, 8'h00, "flag clear");
    end
    // stopped counter ignores falls and later resumes from its value
    wr(`DTC_ADDR_MODE, 8'h55);
    wr(`DTC_ADDR_T0L, 8'h05);
    wr(`DTC_ADDR_T1L, 8'h07);
    pins.fall(0, 2);
    pins.fall(1, 2);
    wr(`DTC_ADDR_CTRL, 8'h50);
    pins.fall(0, 1);
    pins.fall(1, 1);
    rd_chk(`DTC_ADDR_T0L, 8'hff, 8'h06, "t0 resume");
    rd_chk(`DTC_ADDR_T1L, 8'hff, 8'h08, "t1 resume");
    wr(`DTC_ADDR_CTRL, 8'h00);
    // split mode: low byte on pin, high byte prescaled under timer1 run
    wr(`DTC_ADDR_MODE, 8'h57);
    wr(`DTC_ADDR_FREQ, 8'h03);
    wr(`DTC_ADDR_T0L, 8'hfe);
    wr(`DTC_ADDR_T0H, 8'hff);
    wr(`DTC_ADDR_T1L, 8'h00);
    wr(`DTC_ADDR_T1H, 8'h00);
    wr(`DTC_ADDR_CTRL, 8'h50);
    pins.fall(0, 2);
    pins.fall(1, 3);
    rd_chk(`DTC_ADDR_T0L, 8'hff, 8'h00, "split low");
    rd_chk(`DTC_ADDR_CTRL, 8'hff, 8'hf0, "split flags");
    rd_chk(`DTC_ADDR_T1L, 8'hff, 8'h00, "t1 held");
    wr(`DTC_ADDR_IEN, 8'h02);
    // irq lines are registered behind the enable, let them settle
    repeat (2) @(posedge mclk_i);
    check("t0 irq masked", timer0_irq_o, 1'b0);
    check("t1 irq split", timer1_irq_o, 1'b1);
    wr(`DTC_ADDR_CTRL, 8'h10);
    wr(`DTC_ADDR_T0H, 8'h10);
    repeat (30) @(posedge mclk_i);
    rd_chk(`DTC_ADDR_T0H, 8'hff, 8'h10, "split high stop");
    wr(`DTC_ADDR_CTRL, 8'h00);
    presc(0, 1'b1, 120, 124);
    presc(0, 1'b0, 9, 11);
    presc(1, 1'b1, 120, 124);
    presc(1, 1'b0, 9, 11);
    finish_test();
end

endmodule
